// ---- hw/bls_pkg.sv ----
package bls_pkg;

  // Instruction codes presented once per scan slot
  typedef enum logic [2:0] {
    BLS_OP_NONE,
    BLS_OP_SUB,
    BLS_OP_AND,
    BLS_OP_OR,
    BLS_OP_CLC,
    BLS_OP_STEP_DEF,
    BLS_OP_STEP_BEGIN,
    BLS_OP_SCAN_END
  } bls_op_type;

  // Area that a step control bit lives in
  typedef enum logic [1:0] {
    BLS_AREA_OUTPUT,
    BLS_AREA_WORK,
    BLS_AREA_LINK,
    BLS_AREA_RETAINED
  } bls_area_type;

  // One instruction request with its operands
  typedef struct packed {
    logic          valid;
    bls_op_type    op;
    logic          cond;
    logic [15:0]   word_a;
    logic [15:0]   word_b;
    logic          a_indirect;
    logic [15:0]   a_pointer;
    logic          b_indirect;
    logic [15:0]   b_pointer;
    logic          ctrl_none;
    logic [3:0]    ctrl_bit;
    bls_area_type  ctrl_area;
  } bls_req_type;

  // Flag word seen by the ladder program
  typedef struct packed {
    logic carry;
    logic error;
    logic zero;
    logic step_start;
  } bls_flags_type;

  localparam logic [15:0] BLS_CARRY_BIT_ADDR   = 16'h0312;
  localparam logic [15:0] BLS_STEPSTART_ADDR   = 16'h0411;
  localparam logic [15:0] BLS_AREA_LAST_WORD   = 16'h0099;
  localparam int          BLS_DIGITS           = 4;
  localparam logic [3:0]  BLS_DIGIT_MAX        = 4'h9;
  localparam logic [3:0]  BLS_DIGIT_TEN        = 4'ha;
  localparam logic [15:0] BLS_WORD_RESET       = 16'h0000;
  localparam logic [15:0] BLS_CTRL_RESET       = 16'h0000;
  localparam logic [3:0]  BLS_BIT_RESET        = 4'h0;

endpackage : bls_pkg

// ---- hw/bls_core.sv ----
`timescale 1ns/10ps

// Summary of operation
// - Subtract skipped when condition off, else computes
// - Subtract formed as 10000 plus minuend minus
// - Negative result sets carry, stores complement
// - Carry set when minuend below subtrahend plus carry
// - Error on non-BCD minuend or subtrahend digit
// - Error on nonexistent indirectly addressed word
// - Zero flag follows written result word
// - Word AND combines inputs when condition on
// - Word OR combines inputs when condition on
// - Step define marks step, needs no condition
// - Step begin with condition on activates step
// - Steps not begun earlier are skipped entirely
// - Step section ends at bare step define
// - Step completes on next begin or bit off
// - Completed step clears operand bits, reloads timers
// - Control bits survive power loss only if last begun step is retained-area
// - Step-start flag on one scan per step entry
// - Carry clear forces carry off when condition on
module bls_core
  import bls_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire bls_req_type   req,
  input  wire logic          power_fail,
  output logic [15:0]        result_word_reg,
  output logic               result_write_reg,
  output bls_flags_type      flags,
  output logic               step_skip,
  output logic [15:0]        step_ctrl_word,
  output logic               step_clear_reg,
  output logic [3:0]         step_clear_bit_reg
);

  // All four digits decimal
  function automatic logic bcd_ok(input logic [15:0] w);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < BLS_DIGITS; i++) begin
      if (w[4*i +: 4] > BLS_DIGIT_MAX) ok = 1'b0;
    end
    return ok;
  endfunction : bcd_ok

  // Digit-serial borrow chain; final borrow means negative
  function automatic logic [16:0] bcd_sub(input logic [15:0] a,
                                          input logic [15:0] b,
                                          input logic        cin);
    logic [4:0]  d;
    logic        brw;
    logic [15:0] r;
    brw = cin;
    r   = BLS_WORD_RESET;
    for (int i = 0; i < BLS_DIGITS; i++) begin
      d = {1'b0, a[4*i +: 4]} - {1'b0, b[4*i +: 4]} - {4'h0, brw};
      brw = d[4];
      if (brw) d = d + {1'b0, BLS_DIGIT_TEN};
      r[4*i +: 4] = d[3:0];
    end
    return {brw, r};
  endfunction : bcd_sub

  // Indirect word exists only for a BCD pointer inside the area
  function automatic logic ptr_bad(input logic ind,
                                   input logic [15:0] p);
    return ind && (!bcd_ok(p) || (p > BLS_AREA_LAST_WORD));
  endfunction : ptr_bad

  // Decimal value of a BCD word, kept apart from the borrow chain
  function automatic int bcd_val(input logic [15:0] w);
    return 1000 * w[15:12] + 100 * w[11:8] + 10 * w[7:4] + w[3:0];
  endfunction : bcd_val

  logic          carry_reg;
  logic          error_reg;
  logic          zero_reg;
  logic          start_reg;
  logic          start_pending_reg;
  logic          pf_meta_reg;
  logic          pf_sync_reg;
  logic          section_reg;
  logic          exec_reg;
  logic [3:0]    cur_bit_reg;
  logic [15:0]   ctrl_reg;
  logic [15:0]   ran_reg;
  bls_area_type  area_reg;

  logic          run;
  logic          is_sub;
  logic          is_word;
  logic          ind_err;
  logic          bcd_err;
  logic          op_err;
  logic [16:0]   sub_out;
  logic [15:0]   word_out;
  logic          begin_on;
  logic          def_ctrl;
  logic          bit_on;

  // Operands and step decode
  assign run      = req.valid && exec_reg;
  assign is_sub   = run && req.cond && (req.op == BLS_OP_SUB);
  assign is_word  = run && req.cond &&
                    ((req.op == BLS_OP_AND) || (req.op == BLS_OP_OR));
  assign ind_err  = ptr_bad(req.a_indirect, req.a_pointer) ||
                    ptr_bad(req.b_indirect, req.b_pointer);
  assign bcd_err  = is_sub &&
                    !(bcd_ok(req.word_a) && bcd_ok(req.word_b));
  assign op_err   = ind_err || bcd_err;
  assign sub_out  = bcd_sub(req.word_a, req.word_b, carry_reg);
  assign word_out = (req.op == BLS_OP_AND) ?
                    (req.word_a & req.word_b) :
                    (req.word_a | req.word_b);
  assign begin_on = run && req.cond && (req.op == BLS_OP_STEP_BEGIN);
  assign def_ctrl = req.valid && (req.op == BLS_OP_STEP_DEF) &&
                    !req.ctrl_none;
  assign bit_on   = ctrl_reg[req.ctrl_bit];

  // Result word, written only by an executed, error-free op
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_word_reg  <= BLS_WORD_RESET;
      result_write_reg <= 1'b0;
    end else begin
      result_write_reg <= (is_sub || is_word) && !op_err;
      if (is_sub && !op_err) begin
        result_word_reg <= sub_out[15:0];
      end else if (is_word && !op_err) begin
        result_word_reg <= word_out;
      end
    end
  end

  // Carry: set by negative subtract, cleared by carry clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      carry_reg <= 1'b0;
    end else if (is_sub && !op_err) begin
      carry_reg <= sub_out[16];
    end else if (run && req.cond && (req.op == BLS_OP_CLC)) begin
      carry_reg <= 1'b0;
    end
  end

  // Error follows each executed data op; zero only each error-free one
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      error_reg <= 1'b0;
      zero_reg  <= 1'b0;
    end else if (is_sub || is_word) begin
      error_reg <= op_err;
      if (!op_err) begin
        zero_reg <= is_sub ? (sub_out[15:0] == BLS_WORD_RESET) :
                             (word_out == BLS_WORD_RESET);
      end
    end
  end

  // Supply-loss pin is asynchronous: two flops before use
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pf_meta_reg <= 1'b0;
      pf_sync_reg <= 1'b0;
    end else begin
      pf_meta_reg <= power_fail;
      pf_sync_reg <= pf_meta_reg;
    end
  end

  // Control bits; a lost supply wipes all unless the last begun step is retained-area
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= BLS_CTRL_RESET;
      area_reg <= BLS_AREA_OUTPUT;
    end else if (pf_sync_reg) begin
      if (area_reg != BLS_AREA_RETAINED) begin
        ctrl_reg <= BLS_CTRL_RESET;
      end
    end else if (begin_on) begin
      area_reg <= req.ctrl_area;
      ctrl_reg[req.ctrl_bit] <= 1'b1;
      if (section_reg && cur_bit_reg != req.ctrl_bit) begin
        ctrl_reg[cur_bit_reg] <= 1'b0;
      end
    end
  end

  // Section tracking and gating of instructions
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      section_reg <= 1'b0;
      exec_reg    <= 1'b1;
      cur_bit_reg <= BLS_BIT_RESET;
    end else if (req.valid && req.op == BLS_OP_STEP_DEF) begin
      if (req.ctrl_none) begin
        section_reg <= 1'b0;
        exec_reg    <= 1'b1;
      end else begin
        section_reg <= 1'b1;
        cur_bit_reg <= req.ctrl_bit;
        exec_reg    <= bit_on;
      end
    end else if (begin_on) begin
      section_reg <= 1'b1;
    end
  end

  // Which steps ran; completion pulse for operand and timer reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ran_reg            <= BLS_CTRL_RESET;
      step_clear_reg     <= 1'b0;
      step_clear_bit_reg <= BLS_BIT_RESET;
    end else begin
      step_clear_reg <= 1'b0;
      if (begin_on && section_reg && cur_bit_reg != req.ctrl_bit &&
          ran_reg[cur_bit_reg]) begin
        step_clear_reg            <= 1'b1;
        step_clear_bit_reg        <= cur_bit_reg;
        ran_reg[cur_bit_reg]      <= 1'b0;
      end else if (def_ctrl) begin
        ran_reg[req.ctrl_bit] <= bit_on;
        if (!bit_on && ran_reg[req.ctrl_bit]) begin
          step_clear_reg     <= 1'b1;
          step_clear_bit_reg <= req.ctrl_bit;
        end
      end
    end
  end

  // Start flag shows during the scan after a step is entered
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_pending_reg <= 1'b0;
      start_reg         <= 1'b0;
    end else if (req.valid && req.op == BLS_OP_SCAN_END) begin
      start_reg         <= start_pending_reg;
      start_pending_reg <= 1'b0;
    end else if (def_ctrl && bit_on && !ran_reg[req.ctrl_bit]) begin
      start_pending_reg <= 1'b1;
    end
  end

  // Flag outputs, all registered
  assign flags.carry      = carry_reg;
  assign flags.error      = error_reg;
  assign flags.zero       = zero_reg;
  assign flags.step_start = start_reg;
  assign step_skip        = !exec_reg;
  assign step_ctrl_word   = ctrl_reg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_sub_value;
    is_sub && !op_err |=>
      result_write_reg &&
      bcd_val(result_word_reg) ==
        (10000 + bcd_val($past(req.word_a)) -
         bcd_val($past(req.word_b)) - $past(carry_reg)) % 10000;
  endproperty
  a_sub_value: assert property (p_sub_value)
    else $error("subtract result wrong");

  property p_carry;
    is_sub && !op_err |=>
      carry_reg == ({1'b0, $past(req.word_a)} <
                    {1'b0, $past(req.word_b)} + {16'h0, $past(carry_reg)});
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry after subtract wrong");

  property p_no_exec;
    req.valid && !req.cond && req.op inside {BLS_OP_SUB, BLS_OP_AND,
      BLS_OP_OR} |=> !result_write_reg && $stable(result_word_reg);
  endproperty
  a_no_exec: assert property (p_no_exec)
    else $error("op ran with condition off");

  property p_bcd_err;
    is_sub && !bcd_ok(req.word_a) |=> error_reg && !result_write_reg;
  endproperty
  a_bcd_err: assert property (p_bcd_err)
    else $error("non-BCD minuend not flagged");

  property p_ind_err;
    is_word && (ptr_bad(req.a_indirect, req.a_pointer) ||
                ptr_bad(req.b_indirect, req.b_pointer)) |=>
      error_reg && !result_write_reg;
  endproperty
  a_ind_err: assert property (p_ind_err)
    else $error("bad pointer not flagged");

  property p_zero;
    result_write_reg |-> zero_reg == (result_word_reg == BLS_WORD_RESET);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag disagrees with result");

  property p_and;
    is_word && !op_err && req.op == BLS_OP_AND |=>
      result_word_reg == ($past(req.word_a) & $past(req.word_b));
  endproperty
  a_and: assert property (p_and)
    else $error("word AND wrong");

  property p_clc;
    run && req.cond && req.op == BLS_OP_CLC |=> !carry_reg;
  endproperty
  a_clc: assert property (p_clc)
    else $error("carry clear ignored");

  property p_skip;
    step_skip && req.valid |=> !result_write_reg;
  endproperty
  a_skip: assert property (p_skip)
    else $error("instruction ran inside skipped step");

  property p_start_one;
    start_reg && req.valid && req.op == BLS_OP_SCAN_END &&
      !start_pending_reg |=> !start_reg;
  endproperty
  a_start_one: assert property (p_start_one)
    else $error("step start flag held past one scan");

  c_neg_sub: cover property (is_sub && !op_err && sub_out[16]);
  c_step_done: cover property (step_clear_reg);
  c_start: cover property (start_reg);
  c_section_end: cover property (req.valid && req.op == BLS_OP_STEP_DEF
                                 && req.ctrl_none && section_reg);

endmodule : bls_core

// ---- bench/test_bcd_logic_and_step_sequencer.sv ----
`timescale 1ns/10ps

// Counts every compare and reports a mismatch at once
`define CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
  end \
end

module test_bcd_logic_and_step_sequencer
  import bls_pkg::*;
;
  logic          sys_clk;
  logic          rst_n;
  bls_req_type   req;
  logic          power_fail;
  logic [15:0]   result_word_reg;
  logic          result_write_reg;
  bls_flags_type flags;
  logic          step_skip;
  logic [15:0]   step_ctrl_word;
  logic          step_clear_reg;
  logic [3:0]    step_clear_bit_reg;
  int            fails;
  int            check_count;

  bls_core i_dut (
    .sys_clk            (sys_clk),
    .rst_n              (rst_n),
    .req                (req),
    .power_fail         (power_fail),
    .result_word_reg    (result_word_reg),
    .result_write_reg   (result_write_reg),
    .flags              (flags),
    .step_skip          (step_skip),
    .step_ctrl_word     (step_ctrl_word),
    .step_clear_reg     (step_clear_reg),
    .step_clear_bit_reg (step_clear_bit_reg)
  );

  // Free-running 10 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic final_report;
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // One instruction slot; outputs are settled at the next falling edge
  task automatic issue(input bls_op_type op, input logic cond,
                       input logic [15:0] a, input logic [15:0] b);
    req.valid  = 1'b1;
    req.op     = op;
    req.cond   = cond;
    req.word_a = a;
    req.word_b = b;
    @(negedge sys_clk);
  endtask : issue

  // Step instruction on one control bit
  task automatic step(input bls_op_type op, input logic cond,
                      input logic [3:0] bit_idx);
    req.ctrl_bit = bit_idx;
    issue(op, cond, 16'h0000, 16'h0000);
  endtask : step

  // Empty slot, optionally with a supply-loss pulse
  task automatic idle(input logic pf);
    req.valid  = 1'b0;
    power_fail = pf;
    @(negedge sys_clk);
  endtask : idle

  // Hang guard: the whole sequence needs far fewer cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    final_report();
  end

  initial begin
    rst_n      = 1'b0;
    req        = '0;
    power_fail = 1'b0;
    fails      = 0;
    check_count = 0;
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    // Negative difference, then borrow-in from the carry
    issue(BLS_OP_SUB, 1'b1, 16'h0089, 16'h0100);
    `CHK(result_word_reg, 16'h9989)
    `CHK(result_write_reg, 1'b1)
    `CHK(flags.carry, 1'b1)
    `CHK(flags.zero, 1'b0)
    issue(BLS_OP_SUB, 1'b1, 16'h0000, 16'h9989);
    `CHK(result_word_reg, 16'h0010)
    `CHK(flags.carry, 1'b1)
    issue(BLS_OP_CLC, 1'b0, 16'h0000, 16'h0000);
    `CHK(flags.carry, 1'b1)
    `CHK(result_write_reg, 1'b0)
    issue(BLS_OP_CLC, 1'b1, 16'h0000, 16'h0000);
    `CHK(flags.carry, 1'b0)
    issue(BLS_OP_SUB, 1'b0, 16'h0005, 16'h0001);
    `CHK(result_write_reg, 1'b0)
    `CHK(result_word_reg, 16'h0010)
    // Equal to subtrahend plus carry: no borrow, zero result
    issue(BLS_OP_SUB, 1'b1, 16'h0000, 16'h0001);
    `CHK(result_word_reg, 16'h9999)
    issue(BLS_OP_SUB, 1'b1, 16'h0501, 16'h0500);
    `CHK(result_word_reg, 16'h0000)
    `CHK(flags.carry, 1'b0)
    `CHK(flags.zero, 1'b1)
    issue(BLS_OP_SUB, 1'b1, 16'h9999, 16'h0000);
    `CHK(flags.zero, 1'b0)
    // Bad digits leave result and carry alone
    issue(BLS_OP_SUB, 1'b1, 16'h00a0, 16'h0001);
    `CHK(flags.error, 1'b1)
    `CHK(result_write_reg, 1'b0)
    issue(BLS_OP_SUB, 1'b1, 16'h0001, 16'hf000);
    `CHK(flags.error, 1'b1)
    `CHK(result_word_reg, 16'h9999)
    // Bitwise word operations
    issue(BLS_OP_AND, 1'b1, 16'h0f0f, 16'h00ff);
    `CHK(result_word_reg, 16'h000f)
    `CHK(flags.error, 1'b0)
    issue(BLS_OP_OR, 1'b1, 16'h1200, 16'h0034);
    `CHK(result_word_reg, 16'h1234)
    issue(BLS_OP_AND, 1'b1, 16'h00f0, 16'h0f00);
    `CHK(flags.zero, 1'b1)
    issue(BLS_OP_OR, 1'b0, 16'hffff, 16'hffff);
    `CHK(result_write_reg, 1'b0)
    issue(BLS_OP_AND, 1'b0, 16'hffff, 16'hffff);
    `CHK(result_word_reg, 16'h0000)
    // Pointer past the area, pointer not BCD, pointer on the boundary
    req.a_indirect = 1'b1;
    req.a_pointer  = 16'h0100;
    issue(BLS_OP_AND, 1'b1, 16'hffff, 16'hffff);
    `CHK(flags.error, 1'b1)
    `CHK(result_write_reg, 1'b0)
    req.a_pointer = 16'h00a1;
    issue(BLS_OP_OR, 1'b1, 16'hffff, 16'hffff);
    `CHK(flags.error, 1'b1)
    req.a_indirect = 1'b0;
    req.b_indirect = 1'b1;
    req.b_pointer  = 16'h0099;
    issue(BLS_OP_OR, 1'b1, 16'h0f00, 16'h00f0);
    `CHK(result_word_reg, 16'h0ff0)
    `CHK(flags.error, 1'b0)
    req.b_indirect = 1'b0;
    // Step begin, define, start flag for one scan
    req.ctrl_area = BLS_AREA_WORK;
    step(BLS_OP_STEP_BEGIN, 1'b0, 4'h0);
    `CHK(step_ctrl_word, 16'h0000)
    step(BLS_OP_STEP_BEGIN, 1'b1, 4'h0);
    `CHK(step_ctrl_word, 16'h0001)
    step(BLS_OP_STEP_DEF, 1'b0, 4'h0);
    `CHK(step_skip, 1'b0)
    issue(BLS_OP_SCAN_END, 1'b0, 16'h0000, 16'h0000);
    `CHK(flags.step_start, 1'b1)
    step(BLS_OP_STEP_DEF, 1'b0, 4'h0);
    issue(BLS_OP_SCAN_END, 1'b0, 16'h0000, 16'h0000);
    `CHK(flags.step_start, 1'b0)
    // Next begin completes the running step
    step(BLS_OP_STEP_BEGIN, 1'b1, 4'h1);
    `CHK(step_ctrl_word, 16'h0002)
    `CHK(step_clear_reg, 1'b1)
    `CHK(step_clear_bit_reg, 4'h0)
    idle(1'b0);
    `CHK(step_clear_reg, 1'b0)
    step(BLS_OP_STEP_DEF, 1'b0, 4'h0);
    `CHK(step_skip, 1'b1)
    issue(BLS_OP_AND, 1'b1, 16'hffff, 16'hffff);
    `CHK(result_write_reg, 1'b0)
    step(BLS_OP_STEP_DEF, 1'b0, 4'h1);
    `CHK(step_skip, 1'b0)
    step(BLS_OP_STEP_BEGIN, 1'b1, 4'h2);
    `CHK(step_clear_bit_reg, 4'h1)
    req.ctrl_none = 1'b1;
    step(BLS_OP_STEP_DEF, 1'b0, 4'h0);
    `CHK(step_skip, 1'b0)
    req.ctrl_none = 1'b0;
    issue(BLS_OP_AND, 1'b1, 16'h0003, 16'h0001);
    `CHK(result_word_reg, 16'h0001)
    // Supply loss keeps the control word only if the last begun step is retained-area
    // Supply loss reaches the control word two slots late
    req.ctrl_area = BLS_AREA_RETAINED;
    step(BLS_OP_STEP_BEGIN, 1'b1, 4'h3);
    idle(1'b1);
    idle(1'b0);
    idle(1'b0);
    `CHK(step_ctrl_word[3], 1'b1)
    req.ctrl_area = BLS_AREA_LINK;
    step(BLS_OP_STEP_BEGIN, 1'b1, 4'h3);
    idle(1'b1);
    idle(1'b0);
    idle(1'b0);
    `CHK(step_ctrl_word, 16'h0000)
    final_report();
  end

endmodule : test_bcd_logic_and_step_sequencer
